// ---- instr_exec_pkg.sv ----
// Package with opcode patterns, field positions and reset values for the four-instruction executor.
package instr_exec_pkg;
  localparam int INSTR_W = 14;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int DEST_BIT = 7;
  localparam int OPCODE_MSB = 13;
  localparam int OPCODE_LSB = 8;
  localparam int LOAD_OPCODE_LSB = 10;
  localparam logic [6:0] WR_ADDR_RESET = 7'h00;
  localparam logic [7:0] WR_DATA_RESET = 8'h00;
  localparam logic [5:0] OP_OR_LITERAL = 6'h38;
  localparam logic [3:0] OP_LOAD_LITERAL = 4'hC;
  localparam logic [5:0] OP_OR_FILE = 6'h04;
  localparam logic [5:0] OP_MOVE_FILE = 6'h08;
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  typedef enum logic [4:0] {
    OP_NONE      = 5'b00001,
    OP_ORLIT     = 5'b00010,
    OP_ORFILE    = 5'b00100,
    OP_MOVEFILE  = 5'b01000,
    OP_LOADLIT   = 5'b10000
  } instr_kind_e;
endpackage : instr_exec_pkg

// ---- or_and_move_instr_exec.sv ----
// Decoder and one-cycle executor for the literal-OR, file-OR, file-move and literal-load instructions.
//
// What this block does
// - Opcode 111000 with an 8-bit literal ORs the literal into the accumulator.
// - The literal-OR takes a literal from 0 to 255, always writes the accumulator and updates the zero flag.
// - Opcode 000100 ORs the accumulator with the addressed register, writing the accumulator if the destination bit is 0 or the register if it is 1, and updates the zero flag.
// - Opcode 001000 copies the addressed register to the accumulator if the destination bit is 0 or back into the register if it is 1.
// - The register move updates the zero flag from the moved value for either destination, so a self-move is a zero test.
// - Opcode 1100xx loads the literal into the accumulator and leaves the flags alone.
`timescale 1ns/100ps
`default_nettype none
module or_and_move_instr_exec
  import instr_exec_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 rst_b,
  input  wire logic                 instrValid,
  input  wire logic [INSTR_W-1:0]   instrWord,
  input  wire logic [DATA_W-1:0]    fileRdData,
  output logic      [ADDR_W-1:0]    fileAddr,
  output logic      [ADDR_W-1:0]    fileWrAddr,
  output logic      [DATA_W-1:0]    fileWrData,
  output logic                      fileWrEn,
  output logic      [DATA_W-1:0]    acc,
  output logic                      zeroFlag,
  output logic                      instrDone,
  output logic                      instrUnknown
);

  // The register file is read combinationally from the instruction's address field.
  // Its address port is therefore the only output not taken from a flip-flop: a
  // registered address would cost a second cycle per instruction.
  // A register written by one instruction is updated in the register file a cycle later,
  // so an instruction that reads the same register in the very next cycle sees the old
  // value; the surrounding core must space such a pair or forward the value itself.
  instr_kind_e           kind;
  logic [5:0]            opWide;
  logic [3:0]            opNarrow;
  logic [DATA_W-1:0]     literal;
  logic                  destFile;
  logic [DATA_W-1:0]     operandB;
  logic [DATA_W-1:0]     result;
  logic                  updZero;
  logic                  toAcc;
  logic                  toFile;
  logic                  isKnown;
  logic [ADDR_W-1:0]     wrAddr_reg;
  logic [ADDR_W-1:0]     wrAddr_next;
  logic [DATA_W-1:0]     wrData_reg;
  logic [DATA_W-1:0]     wrData_next;
  logic                  wrEn_reg;
  logic                  wrEn_next;
  logic [DATA_W-1:0]     acc_reg;
  logic [DATA_W-1:0]     acc_next;
  logic                  zero_reg;
  logic                  zero_next;
  logic                  done_reg;
  logic                  done_next;
  logic                  unknown_reg;
  logic                  unknown_next;

  assign opWide   = instrWord[OPCODE_MSB:OPCODE_LSB];
  assign opNarrow = instrWord[OPCODE_MSB:LOAD_OPCODE_LSB];
  assign literal  = instrWord[DATA_W-1:0];
  assign destFile = instrWord[DEST_BIT];
  assign fileAddr = instrWord[ADDR_W-1:0];

  // The four patterns never overlap, so the order of this chain only matters for readability.
  always_comb begin
    kind = OP_NONE;
    if (opWide == OP_OR_LITERAL) begin
      kind = OP_ORLIT;
    end else if (opNarrow == OP_LOAD_LITERAL) begin
      kind = OP_LOADLIT;
    end else if (opWide == OP_OR_FILE) begin
      kind = OP_ORFILE;
    end else if (opWide == OP_MOVE_FILE) begin
      kind = OP_MOVEFILE;
    end
  end

  // The second operand is the literal for the immediate forms and the register otherwise,
  // so one OR gate serves both OR instructions.
  always_comb begin
    operandB = fileRdData;
    if (kind == OP_ORLIT || kind == OP_LOADLIT) begin
      operandB = literal;
    end
  end

  // Works out the result and where it goes; no state is touched here.
  always_comb begin
    result  = operandB;
    updZero = 1'b0;
    toAcc   = 1'b0;
    toFile  = 1'b0;
    isKnown = 1'b1;
    case (kind)
      OP_ORLIT: begin
        result  = acc_reg | operandB;
        toAcc   = 1'b1;
        updZero = 1'b1;
      end
      OP_ORFILE: begin
        result  = acc_reg | operandB;
        updZero = 1'b1;
        if (destFile) begin
          toFile = 1'b1;
        end else begin
          toAcc = 1'b1;
        end
      end
      OP_MOVEFILE: begin
        result  = operandB;
        updZero = 1'b1;
        if (destFile) begin
          toFile = 1'b1;
        end else begin
          toAcc = 1'b1;
        end
      end
      OP_LOADLIT: begin
        result = operandB;
        toAcc  = 1'b1;
      end
      default: begin
        // Other opcodes belong to the rest of the core; they are flagged, not executed.
        isKnown = 1'b0;
      end
    endcase
  end

  // The next instruction, even in the very next cycle, already sees the new accumulator.
  always_comb begin
    acc_next = acc_reg;
    if (instrValid && toAcc) begin
      acc_next = result;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_reg <= ACC_RESET;
    end else begin
      acc_reg <= acc_next;
    end
  end

  // The load-literal instruction never enables the update, so the flag holds across it.
  // Both destinations of the register forms update it, which makes a self-move a zero test.
  always_comb begin
    zero_next = zero_reg;
    if (instrValid && updZero) begin
      zero_next = (result == '0);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      zero_reg <= ZERO_RESET;
    end else begin
      zero_reg <= zero_next;
    end
  end

  // Address, data and strobe are registered together so the register file sees one
  // consistent write in the cycle after the instruction, with the strobe lasting that cycle only.
  always_comb begin
    wrAddr_next = wrAddr_reg;
    wrData_next = wrData_reg;
    wrEn_next   = 1'b0;
    if (instrValid && toFile) begin
      wrEn_next   = 1'b1;
      wrAddr_next = fileAddr;
      wrData_next = result;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wrAddr_reg <= WR_ADDR_RESET;
      wrData_reg <= WR_DATA_RESET;
      wrEn_reg   <= 1'b0;
    end else begin
      wrAddr_reg <= wrAddr_next;
      wrData_reg <= wrData_next;
      wrEn_reg   <= wrEn_next;
    end
  end

  // Each status pulse lasts one cycle; an unknown opcode changes nothing but its own pulse,
  // which lets the surrounding core hand that word to its other execution paths.
  always_comb begin
    done_next    = 1'b0;
    unknown_next = 1'b0;
    if (instrValid) begin
      if (isKnown) begin
        done_next = 1'b1;
      end else begin
        unknown_next = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      done_reg    <= 1'b0;
      unknown_reg <= 1'b0;
    end else begin
      done_reg    <= done_next;
      unknown_reg <= unknown_next;
    end
  end

  assign acc          = acc_reg;
  assign zeroFlag     = zero_reg;
  assign fileWrEn     = wrEn_reg;
  assign fileWrAddr   = wrAddr_reg;
  assign fileWrData   = wrData_reg;
  assign instrDone    = done_reg;
  assign instrUnknown = unknown_reg;

endmodule // or_and_move_instr_exec
`default_nettype wire

// ---- or_and_move_instr_exec_assertions.sv ----
// Port assertions for the executor.
`timescale 1ns/100ps
`default_nettype none
module or_and_move_instr_exec_checker
  import instr_exec_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_b,
  input wire logic        instrValid,
  input wire logic [13:0] instrWord,
  input wire logic [7:0]  fileRdData,
  input wire logic [6:0]  fileWrAddr,
  input wire logic [7:0]  fileWrData,
  input wire logic        fileWrEn,
  input wire logic [7:0]  acc,
  input wire logic        zeroFlag,
  input wire logic        instrDone,
  input wire logic        instrUnknown
);
  wire logic [5:0] op = instrWord[13:8];
  wire logic [7:0] k = instrWord[7:0];
  wire logic orL = instrValid && op == OP_OR_LITERAL;
  wire logic ld = instrValid && op[5:2] == OP_LOAD_LITERAL;
  wire logic mv = instrValid && op == OP_MOVE_FILE;
  wire logic orF = instrValid && op == OP_OR_FILE;
  wire logic unk = instrValid && !(orL || ld || mv || orF);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_lit_or: assert property (orL |=> acc == ($past(acc) | $past(k))) else $error("bad acc");
  a_lit_zero: assert property (orL |=> zeroFlag == (acc == 8'h00)) else $error("bad zero");
  a_file_dest: assert property (orF && k[7] |=> fileWrEn && acc == $past(acc)) else $error("bad dest");
  a_move_acc: assert property (mv && !k[7] |=> acc == $past(fileRdData) && !fileWrEn) else $error("bad move");
  a_move_zero: assert property (mv |=> zeroFlag == ($past(fileRdData) == 8'h00)) else $error("bad test");
  a_load_keep: assert property (ld |=> acc == $past(k) && $stable(zeroFlag)) else $error("bad load");
  a_done_pulse: assert property (orL || ld || mv || orF |=> instrDone) else $error("no done");
  a_or_acc: assert property (orF && !k[7] |=> acc == ($past(acc) | $past(fileRdData)) && !fileWrEn)
    else $error("bad or");
  a_or_wdata: assert property (orF && k[7] |=> fileWrData == ($past(acc) | $past(fileRdData)))
    else $error("bad write");
  a_or_zero: assert property (orF |=> zeroFlag == (($past(acc) | $past(fileRdData)) == 8'h00))
    else $error("bad or zero");
  a_move_write: assert property (mv && k[7] |=> fileWrEn && fileWrData == $past(fileRdData) && acc == $past(acc))
    else $error("bad write");
  a_write_addr: assert property ((orF || mv) && k[7] |=> fileWrAddr == $past(instrWord[6:0]))
    else $error("bad addr");
  a_unknown_quiet: assert property (unk |=> instrUnknown && !instrDone && !fileWrEn && $stable(acc))
    else $error("bad unknown");
endmodule // or_and_move_instr_exec_checker
bind or_and_move_instr_exec or_and_move_instr_exec_checker chk (
  .clk          (clk),
  .rst_b        (rst_b),
  .instrValid   (instrValid),
  .instrWord    (instrWord),
  .fileRdData   (fileRdData),
  .fileWrAddr   (fileWrAddr),
  .fileWrData   (fileWrData),
  .fileWrEn     (fileWrEn),
  .acc          (acc),
  .zeroFlag     (zeroFlag),
  .instrDone    (instrDone),
  .instrUnknown (instrUnknown)
);
`default_nettype wire

// ---- or_and_move_instr_exec_test.sv ----
// Random test of the executor.
`timescale 1ns/100ps
`default_nettype none
module or_and_move_instr_exec_test
  import instr_exec_pkg::*;
;
  logic        clk = 1'b0, rst_b = 1'b0, instrValid = 1'b0, fileWrEn, zeroFlag, instrDone, instrUnknown, ez, ew, ed, eu;
  logic [13:0] instrWord = '0;
  logic [13:0] corner [4] = '{14'h3000, 14'h3800, 14'h0880, 14'h3FFF};
  logic [7:0]  fileRdData = '0, fileWrData, acc, ea, res;
  logic [6:0]  fileAddr, fileWrAddr, ewa;
  logic [15:0] r = 16'h51ED;
  int          bad_count = 0, checks = 0;
  always #5 clk = ~clk;
  or_and_move_instr_exec dut (
    .clk          (clk),
    .rst_b        (rst_b),
    .instrValid   (instrValid),
    .instrWord    (instrWord),
    .fileRdData   (fileRdData),
    .fileAddr     (fileAddr),
    .fileWrAddr   (fileWrAddr),
    .fileWrData   (fileWrData),
    .fileWrEn     (fileWrEn),
    .acc          (acc),
    .zeroFlag     (zeroFlag),
    .instrDone    (instrDone),
    .instrUnknown (instrUnknown)
  );
  function automatic logic [15:0] lfsr(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  // Literal forms have bit 13 set; only the two OR forms fold in the accumulator.
  function automatic logic [7:0] op_result(logic [13:0] w, logic [7:0] rd, a);
    return (w[13] ? w[7:0] : rd) | (w[10] || &w[13:11] ? a : 8'h00);
  endfunction
  task automatic chk(string n, logic [7:0] s, e);
    checks++;
    bad_count += int'(s !== e);
    if (s !== e) $display("CHECK FAILED %s %h %h", n, e, s);
  endtask
  task automatic stop_test;
    if (bad_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    // The second pass starts with a reset in mid-run, taken on a clock edge.
    for (int p = 0; p < 2; p++) begin
      if (p != 0) @(posedge clk);
      rst_b <= 1'b0;
      instrValid <= 1'b0;
      {ez, ew, ed, eu, ea, ewa} = '0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      for (int i = 0; i < 300; i++) begin
        r = lfsr(r);
        @(posedge clk);
        instrValid <= (i < 4) || !(r[3] && r[9]);
        instrWord <= (i < 4) ? corner[i[1:0]] : {r[2] ? (&r[1:0] ? 6'h3F : OP_MOVE_FILE) : r[1] ? OP_OR_FILE
          : r[0] ? OP_OR_LITERAL : {OP_LOAD_LITERAL, r[6:5]}, r[4] ? 8'h00 : r[15:8]};
        fileRdData <= (r[7] || i < 4) ? 8'h00 : r[13:6];
        @(negedge clk);
        chk("acc", acc, ea);
        chk("flags", {4'h0, instrUnknown, zeroFlag, fileWrEn, instrDone}, {4'h0, eu, ez, ew, ed});
        chk("fileAddr", {1'b0, fileAddr}, {1'b0, instrWord[6:0]});
        if (ew) chk("fileWrData", fileWrData, res);
        if (ew) chk("fileWrAddr", {1'b0, fileWrAddr}, {1'b0, ewa});
        res = op_result(instrWord, fileRdData, ea);
        eu = instrValid && instrWord[13:8] == 6'h3F;
        ed = instrValid && !eu;
        ew = ed && !instrWord[13] && instrWord[DEST_BIT];
        ewa = instrWord[6:0];
        if (ed && instrWord[11:10] != 2'b00) ez = res == 8'h00;
        if (ed && !ew) ea = res;
      end
    end
    stop_test();
  end
endmodule // or_and_move_instr_exec_test
`default_nettype wire
